// File: osd_attr.sv
// Row attribute registers and per-character attribute decode
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01 - Colour source select 0: RGB shows character colour, cursor bit ignored.
// R02 - Source select 1 and cursor bit 1: RGB shows the row cursor colour.
// R03 - Button bits decode none, start, end, single alike for both styles.
// R04 - Software keeps inner button characters as none or single codes.
// R05 - RGB carries the 3-bit character colour in both display modes.
// R06 - Text mode composite phase follows character colour; black, white no chroma.
// R07 - Superimposed mode composite characters are always white.
// R08 - Nine-bit code selects glyph up to 17F; code 000 shows nothing.
// R09 - Software avoids codes 180 through 1FF.
// R10 - Twelve 8-bit read/write row registers, one per display row.
// R11 - Row registers clear to 00 on reset and on module stop.
// R12 - With vsync update set, new row values apply only at overlay vsync.
// R13 - Row style bit: 0 raised buttons, 1 lowered buttons.
// R14 - Row size bit selects double height and width, borders and buttons too.
// R15 - Character brightness field sets composite IRE per colour class.
// R16 - Character brightness sets composite luma only, never the RGB digital outputs.
// R17 - Row cursor colour uses the character colour mapping.
// R18 - Superimposed composite ignores cursor colour, shows halftone; RGB keeps it.
// R19 - Cursor only in text mode; halftone only in superimposed mode.
// R20 - Text cursor brightness bit: black 0 or 25, chromatic 25 or 45 IRE.
// R21 - Superimposed: same bit picks 50 percent or 30 percent halftone.
// R22 - Per-character cursor bit means halftone or cursor by display mode.
// R23 - Each scanned row uses the row register matching its index.
module osd_attr
   import osd_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Video scan input
   input wire logic overlay_vsync,
   input wire logic char_valid,
   input wire logic [3:0] char_row,
   input wire logic [15:0] char_word,
   // Decoded pixel attributes
   output osd_pix_t pix
);

   typedef struct packed {
      logic [OSD_ROWS-1:0][7:0] regs;
      logic [OSD_ROWS-1:0][7:0] live;
      logic [3:0] ctrl;
      logic pend;
      logic vs_d;
      logic aw_got;
      logic [5:0] aw;
      logic w_got;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      osd_pix_t pix;
   } osd_st_t;

   osd_st_t st, next_st;

   function automatic logic [3:0] col_phase(input logic [2:0] c);
      case (c)
         3'h1: col_phase = PH_PI;
         3'h2: col_phase = PH_7PI_4;
         3'h3: col_phase = PH_3PI_2;
         3'h4: col_phase = PH_PI_2;
         3'h5: col_phase = PH_3PI_4;
         3'h6: col_phase = PH_ZERO;
         default: col_phase = PH_NONE;
      endcase
   endfunction

   function automatic logic [6:0] char_ire(input logic [2:0] c,
                                           input logic [1:0] l);
      logic [6:0] r;
      r = IRE_CHROM_0;
      if (c == COL_BLACK) begin
         case (l)
            2'h0: r = IRE_BLACK_0;
            2'h1: r = IRE_BLACK_1;
            2'h2: r = IRE_BLACK_2;
            default: r = IRE_BLACK_3;
         endcase
      end else if (c == COL_WHITE) begin
         case (l)
            2'h0: r = IRE_WHITE_0;
            2'h1: r = IRE_WHITE_1;
            2'h2: r = IRE_WHITE_2;
            default: r = IRE_WHITE_3;
         endcase
      end else begin
         case (l)
            2'h0: r = IRE_CHROM_0;
            2'h1: r = IRE_CHROM_1;
            2'h2: r = IRE_CHROM_2;
            default: r = IRE_CHROM_3;
         endcase
      end
      char_ire = r;
   endfunction

   // Row index of a register address, or OSD_ROWS when not a row
   function automatic logic [3:0] row_of(input logic [5:0] a);
      logic [3:0] i;
      i = a[5:2];
      if (a[1:0] != 2'h0 || i >= 4'(OSD_ROWS)) begin
         i = 4'(OSD_ROWS);
      end
      row_of = i;
   endfunction

   logic do_wr;
   logic do_rd;
   logic vs_rise;
   logic [7:0] ra;
   logic [2:0] ccol;
   logic [2:0] kcol;
   logic text_mode;
   logic cur_bit;
   logic [3:0] wrow;
   logic [3:0] rrow;

   assign s_axi_awready = !st.aw_got && !st.bvalid;
   assign s_axi_wready = !st.w_got && !st.bvalid;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign pix = st.pix;

   always_comb begin
      next_st = st;
      do_wr = st.aw_got && st.w_got && !st.bvalid;
      do_rd = s_axi_arvalid && !st.rvalid;
      vs_rise = overlay_vsync && !st.vs_d;
      wrow = row_of(st.aw);
      rrow = row_of(s_axi_araddr);
      next_st.vs_d = overlay_vsync;
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wd = s_axi_wdata;
         next_st.ws = s_axi_wstrb;
      end
      if (do_wr) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         if (wrow < 4'(OSD_ROWS)) begin
            if (st.ws[0]) begin
               next_st.regs[wrow] = st.wd[7:0]; // [R10]
               next_st.pend = 1'b1;
            end
         end else if (st.aw == OSD_CTRL_OFS) begin
            if (st.ws[0]) begin
               next_st.ctrl = st.wd[3:0];
            end
         end else begin
            next_st.bresp = RESP_SLVERR;
         end
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (do_rd) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         next_st.rdata = 32'h00000000;
         if (rrow < 4'(OSD_ROWS)) begin
            next_st.rdata = {24'h000000, st.regs[rrow]};
         end else if (s_axi_araddr == OSD_CTRL_OFS) begin
            next_st.rdata = {28'h0000000, st.ctrl};
         end else begin
            next_st.rresp = RESP_SLVERR;
         end
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // Copy shadow rows into the live set
      if (!st.ctrl[CTL_VSYNC_UPD] || (st.pend && vs_rise)) begin // [R12]
         next_st.live = next_st.regs;
         next_st.pend = 1'b0;
      end
      if (st.ctrl[CTL_STOP]) begin
         next_st.regs = '0; // [R11]
         next_st.live = '0; // [R11]
         next_st.pend = 1'b0;
      end
      // Per-character decode
      ra = (char_row < 4'(OSD_ROWS)) ? st.live[char_row] : 8'h00; // [R23]
      ccol = char_word[DW_COL_HI:DW_COL_LO];
      kcol = ra[RA_KCOL_HI:RA_KCOL_LO];
      text_mode = st.ctrl[CTL_MODE];
      cur_bit = char_word[DW_HTCR];
      next_st.pix.valid = char_valid;
      next_st.pix.glyph = char_word[8:0]; // [R08]
      next_st.pix.glyph_show = (char_word[8:0] != CODE_BLANK) &&
         (char_word[8:0] <= CODE_LAST); // [R08]
      next_st.pix.button = osd_btn_t'(char_word[DW_BTN_HI:DW_BTN_LO]); // [R03]
      next_st.pix.button_lowered = ra[RA_STYLE]; // [R13]
      next_st.pix.double_size = ra[RA_SIZE]; // [R14]
      // RGB colour never depends on brightness bits
      if (st.ctrl[CTL_RGB_SRC] && cur_bit) begin
         next_st.pix.rgb = kcol; // [R02] [R18] [R16]
      end else begin
         next_st.pix.rgb = ccol; // [R01] [R05]
      end
      next_st.pix.cursor_on = text_mode && cur_bit; // [R19] [R22]
      next_st.pix.halftone_on = !text_mode && cur_bit; // [R19] [R22]
      next_st.pix.halftone = ra[RA_KLUMA] ? HALFTONE_30 : HALFTONE_50; // [R21]
      if (!text_mode) begin
         next_st.pix.phase = PH_NONE; // [R07] [R18]
         next_st.pix.luma = char_ire(COL_WHITE,
            ra[RA_LUMA_HI:RA_LUMA_LO]); // [R07] [R15]
      end else if (cur_bit) begin
         next_st.pix.phase = col_phase(kcol); // [R17]
         if (kcol == COL_BLACK) begin
            next_st.pix.luma = ra[RA_KLUMA] ? IRE_KBLACK_1 : IRE_BLACK_0;
         end else begin
            next_st.pix.luma = ra[RA_KLUMA] ? IRE_KCHROM_1
                                            : IRE_KCHROM_0; // [R20]
         end
      end else begin
         next_st.pix.phase = col_phase(ccol); // [R06]
         next_st.pix.luma = char_ire(ccol,
            ra[RA_LUMA_HI:RA_LUMA_LO]); // [R15]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0; // [R11]
      end else begin
         st <= next_st;
      end
   end

   // Assertions
   a_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_STOP] |=> (st.live == '0)) // [R11]
      else $error("rows not cleared in stop");
   a_rgb_char: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.ctrl[CTL_RGB_SRC] |=> pix.rgb == $past(ccol)) // [R01]
      else $error("rgb not character colour");
   a_rgb_cursor: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_RGB_SRC] && cur_bit |=> pix.rgb == $past(kcol)) // [R02]
      else $error("rgb not cursor colour");
   a_super_white: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.ctrl[CTL_MODE] |=> pix.phase == PH_NONE && !pix.cursor_on) // [R07]
      else $error("superimposed not white");
   a_blank_code: assert property (@(posedge aclk) disable iff (!aresetn)
      char_word[8:0] == CODE_BLANK |=> !pix.glyph_show) // [R08]
      else $error("blank code shown");
   a_ht_level: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
      !st.ctrl[CTL_MODE] && cur_bit |=> pix.halftone_on &&
      pix.halftone == ($past(ra[RA_KLUMA]) ? HALFTONE_30 : HALFTONE_50))
      else $error("bad halftone level");
   a_vsync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_VSYNC_UPD] && !st.ctrl[CTL_STOP] && !(st.pend && vs_rise)
      |=> st.live == $past(st.live)) // [R12]
      else $error("live rows changed off vsync");
   a_text_phase: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_MODE] && !cur_bit && ccol == 3'h1
      |=> pix.phase == PH_PI) // [R06]
      else $error("blue phase wrong");

   // Register bus and row storage
   a_stop_regs: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_STOP] |=> (st.regs == '0)) // [R11]
      else $error("shadow rows not cleared in stop");
   a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      do_wr && wrow < 4'(OSD_ROWS) && st.ws[0] && !st.ctrl[CTL_STOP]
      |=> st.regs[$past(wrow)] == $past(st.wd[7:0]))
      else $error("row write lost");
   a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      do_wr && wrow >= 4'(OSD_ROWS) && st.aw != OSD_CTRL_OFS
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_read_row: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      do_rd && rrow < 4'(OSD_ROWS) |=> s_axi_rvalid &&
      s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h000000)
      else $error("row read answer wrong");
   a_busy_ready: assert property (@(posedge aclk) disable iff (!aresetn)
      st.bvalid |-> !s_axi_awready && !s_axi_wready) // [R10]
      else $error("write taken while response pending");
   a_live_direct: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      !st.ctrl[CTL_VSYNC_UPD]
      |=> st.live == st.regs)
      else $error("live rows lag without vsync update");
   a_live_vsync: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      st.pend && vs_rise
      |=> st.live == st.regs)
      else $error("live rows not copied at vsync");

   // Per-character decode
   a_cursor_phase: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
      st.ctrl[CTL_MODE] && cur_bit && kcol == 3'h5
      |=> pix.phase == PH_3PI_4)
      else $error("cursor phase wrong");
   a_white_luma: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      !st.ctrl[CTL_MODE] && ra[RA_LUMA_HI:RA_LUMA_LO] == 2'h2
      |=> pix.luma == IRE_WHITE_2)
      else $error("superimposed luma not white");
   a_black_luma: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
      st.ctrl[CTL_MODE] && !cur_bit && ccol == COL_BLACK &&
      ra[RA_LUMA_HI:RA_LUMA_LO] == 2'h3 |=> pix.luma == IRE_BLACK_3)
      else $error("black character luma wrong");
   a_kblack_luma: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
      st.ctrl[CTL_MODE] && cur_bit && kcol == COL_BLACK && ra[RA_KLUMA]
      |=> pix.luma == IRE_KBLACK_1)
      else $error("black cursor luma wrong");
   a_ht_text: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTL_MODE] |=> !pix.halftone_on) // [R19]
      else $error("halftone in text mode");
   a_sup_rgb: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
      !st.ctrl[CTL_MODE] && st.ctrl[CTL_RGB_SRC] && cur_bit
      |=> pix.rgb == $past(kcol) && pix.halftone_on)
      else $error("superimposed cursor rgb wrong");
   a_button_end: assert property (@(posedge aclk) disable iff (!aresetn)
      char_word[DW_BTN_HI:DW_BTN_LO] == 2'h2 |=> pix.button == OSD_BTN_END) // [R03]
      else $error("button end not decoded");
   a_row_pick: assert property (@(posedge aclk) disable iff (!aresetn) // [R23]
      char_row == 4'h1
      |=> pix.double_size == $past(st.live[1][RA_SIZE]))
      else $error("row attributes not from own row");
   a_glyph_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> pix.glyph == $past(char_word[8:0])) // [R08]
      else $error("glyph code not passed");
   a_pix_valid: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> pix.valid == $past(char_valid)) // [R23]
      else $error("pixel valid not one cycle late");
   c_vsync_update: cover property (@(posedge aclk) disable iff (!aresetn)
      st.pend && vs_rise && st.ctrl[CTL_VSYNC_UPD]);
   c_cursor: cover property (@(posedge aclk) disable iff (!aresetn)
      pix.cursor_on);
   c_halftone: cover property (@(posedge aclk) disable iff (!aresetn)
      pix.halftone_on);
   c_button_end: cover property (@(posedge aclk) disable iff (!aresetn)
      pix.button == OSD_BTN_END && pix.button_lowered);
   c_double: cover property (@(posedge aclk) disable iff (!aresetn)
      pix.double_size && pix.valid);

endmodule
`default_nettype wire

// File: osd_pkg.sv
// Package for the on-screen-display row attribute decoder
package osd_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [5:0] OSD_ROW_ATTR_BASE = 6'h00;
   localparam logic [5:0] OSD_CTRL_OFS = 6'h30;
   localparam logic [5:0] OSD_LAST_OFS = 6'h30;
   localparam int OSD_ROWS = 12;
   localparam logic [7:0] OSD_ROW_RESET = 8'h00;

   // Row register fields
   localparam int RA_STYLE = 7;
   localparam int RA_SIZE = 6;
   localparam int RA_LUMA_HI = 5;
   localparam int RA_LUMA_LO = 4;
   localparam int RA_KCOL_HI = 3;
   localparam int RA_KCOL_LO = 1;
   localparam int RA_KLUMA = 0;

   // Control register fields
   localparam int CTL_VSYNC_UPD = 0;
   localparam int CTL_MODE = 1;
   localparam int CTL_RGB_SRC = 2;
   localparam int CTL_STOP = 3;

   // Display word fields
   localparam int DW_HTCR = 14;
   localparam int DW_BTN_HI = 13;
   localparam int DW_BTN_LO = 12;
   localparam int DW_COL_HI = 11;
   localparam int DW_COL_LO = 9;
   localparam logic [8:0] CODE_BLANK = 9'h000;
   localparam logic [8:0] CODE_LAST = 9'h17F;

   // Colours
   localparam logic [2:0] COL_BLACK = 3'h0;
   localparam logic [2:0] COL_WHITE = 3'h7;

   // Brightness in IRE
   localparam logic [6:0] IRE_BLACK_0 = 7'h00;
   localparam logic [6:0] IRE_BLACK_1 = 7'h0A;
   localparam logic [6:0] IRE_BLACK_2 = 7'h14;
   localparam logic [6:0] IRE_BLACK_3 = 7'h1E;
   localparam logic [6:0] IRE_CHROM_0 = 7'h19;
   localparam logic [6:0] IRE_CHROM_1 = 7'h2D;
   localparam logic [6:0] IRE_CHROM_2 = 7'h37;
   localparam logic [6:0] IRE_CHROM_3 = 7'h41;
   localparam logic [6:0] IRE_WHITE_0 = 7'h2D;
   localparam logic [6:0] IRE_WHITE_1 = 7'h46;
   localparam logic [6:0] IRE_WHITE_2 = 7'h50;
   localparam logic [6:0] IRE_WHITE_3 = 7'h5A;
   localparam logic [6:0] IRE_KBLACK_1 = 7'h19;
   localparam logic [6:0] IRE_KCHROM_0 = 7'h19;
   localparam logic [6:0] IRE_KCHROM_1 = 7'h2D;

   // Halftone levels in percent
   localparam logic [6:0] HALFTONE_50 = 7'h32;
   localparam logic [6:0] HALFTONE_30 = 7'h1E;

   // Chroma phase in eighths of a turn; 4'hF marks no chroma
   localparam logic [3:0] PH_NONE = 4'hF;
   localparam logic [3:0] PH_ZERO = 4'h0;
   localparam logic [3:0] PH_PI_2 = 4'h2;
   localparam logic [3:0] PH_3PI_4 = 4'h3;
   localparam logic [3:0] PH_PI = 4'h4;
   localparam logic [3:0] PH_3PI_2 = 4'h6;
   localparam logic [3:0] PH_7PI_4 = 4'h7;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      OSD_BTN_NONE = 2'h0,
      OSD_BTN_START = 2'h1,
      OSD_BTN_END = 2'h2,
      OSD_BTN_SINGLE = 2'h3
   } osd_btn_t;

   typedef struct packed {
      logic [2:0] rgb;
      logic [3:0] phase;
      logic [6:0] luma;
      logic [6:0] halftone;
      logic halftone_on;
      logic cursor_on;
      osd_btn_t button;
      logic button_lowered;
      logic double_size;
      logic [8:0] glyph;
      logic glyph_show;
      logic valid;
   } osd_pix_t;

endpackage

// File: osd_tv_model.sv
// Video monitor model that latches each decoded character it receives
`timescale 1ns/1ps
`default_nettype none
module osd_tv_model
   import osd_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Decoded attributes in
   input wire osd_pix_t pix,
   // Last character shown
   output osd_pix_t seen
);
   always_ff @(posedge aclk) begin
      if (pix.valid) begin
         seen <= pix;
      end
   end
endmodule
`default_nettype wire

// File: osd_row_char_attribute_decode_tb.sv
// Self-checking bench for the row attribute decoder
`timescale 1ns/1ps
`default_nettype none
module osd_row_char_attribute_decode_tb
   import osd_pkg::*;
;
   logic aclk, aresetn, vsync, cvalid;
   logic [5:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, resp;
   logic [3:0] crow, wstrb;
   logic [15:0] cword;
   osd_pix_t pix, seen;
   int n_errors, check_count;
   logic [6:0] lb[4] = '{IRE_BLACK_0, IRE_BLACK_1, IRE_BLACK_2, IRE_BLACK_3};
   logic [6:0] lc[4] = '{IRE_CHROM_0, IRE_CHROM_1, IRE_CHROM_2, IRE_CHROM_3};
   logic [6:0] lw[4] = '{IRE_WHITE_0, IRE_WHITE_1, IRE_WHITE_2, IRE_WHITE_3};
   logic [3:0] ph[8] = '{PH_NONE, PH_PI, PH_7PI_4, PH_3PI_2, PH_PI_2,
      PH_3PI_4, PH_ZERO, PH_NONE};

   osd_attr dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .overlay_vsync(vsync), .char_valid(cvalid),
      .char_row(crow), .char_word(cword), .pix(pix));
   osd_tv_model tv (.aclk(aclk), .pix(pix), .seen(seen));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [5:0] ra(input int i);
      return OSD_ROW_ATTR_BASE + 6'(4 * i);
   endfunction

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic ag, wg, bg;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bg = 1'b0;
      while (!bg) begin
         @(negedge aclk);
         ag = awvalid && awready;
         wg = wvalid && wready;
         bg = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ag) awvalid <= 1'b0;
         if (wg) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      logic ag, rg;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rg = 1'b0;
      while (!rg) begin
         @(negedge aclk);
         ag = arvalid && arready;
         rg = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ag) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task automatic px(input logic [3:0] r, input logic [15:0] w);
      @(posedge aclk);
      cvalid <= 1'b1;
      crow <= r;
      cword <= w;
      @(posedge aclk);
      cvalid <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      for (int i = 0; i < OSD_ROWS; i++) begin
         rd(ra(i), d);
         chk("row reset", 32'(OSD_ROW_RESET), d);
         wr(ra(i), 8'(8'hA1 + i));
      end
      for (int i = 0; i < OSD_ROWS; i++) begin
         rd(ra(i), d);
         chk("row readback", 32'(8'hA1 + i), d);
      end
      wstrb <= 4'hE;
      wr(ra(0), 8'h5A);
      wstrb <= 4'hF;
      rd(ra(0), d);
      chk("strobe off", 32'h000000A1, d);
      rd(6'h34, d);
      chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
      wr(6'h38, 8'h5A);
      chk("unmapped write", 32'(RESP_SLVERR), 32'(resp));
      $display("done registers");
   endtask

   task automatic t_text;
      wr(OSD_CTRL_OFS, 8'h02);
      for (int f = 0; f < 4; f++) begin
         wr(ra(0), 8'(f << 4));
         for (int c = 0; c < 8; c++) begin
            px(4'h0, 16'(c << 9) | 16'h0041);
            chk("text rgb", 32'(c), 32'(seen.rgb));
            chk("text phase", 32'(ph[c]), 32'(seen.phase));
            chk("text luma", 32'((c == 0) ? lb[f] : (c == 7) ? lw[f]
               : lc[f]), 32'(seen.luma));
         end
      end
      $display("done text colours");
   endtask

   task automatic t_super;
      wr(OSD_CTRL_OFS, 8'h00);
      for (int k = 0; k < 2; k++) begin
         wr(ra(0), 8'(8'h2A + k));
         px(4'h0, 16'h4641);
         chk("sup rgb", 32'h3, 32'(seen.rgb));
         chk("sup phase", 32'(PH_NONE), 32'(seen.phase));
         chk("sup luma", 32'(IRE_WHITE_2), 32'(seen.luma));
         chk("sup halftone", 32'h1, 32'(seen.halftone_on));
         chk("sup cursor", 32'h0, 32'(seen.cursor_on));
         chk("sup level", 32'(k ? HALFTONE_30 : HALFTONE_50),
            32'(seen.halftone));
      end
      px(4'h0, 16'h0641);
      chk("sup halftone off", 32'h0, 32'(seen.halftone_on));
      $display("done superimposed");
   endtask

   task automatic cs(input logic [7:0] c, r, input logic [15:0] w,
         input logic [2:0] e, input logic k);
      wr(OSD_CTRL_OFS, c);
      wr(ra(0), r);
      px(4'h0, w);
      chk("digital rgb", 32'(e), 32'(seen.rgb));
      chk("cursor on", 32'(k), 32'(seen.cursor_on));
      chk("halftone on", 32'(w[DW_HTCR] && !c[CTL_MODE]),
         32'(seen.halftone_on));
   endtask

   task automatic t_cursor;
      cs(8'h06, 8'h0B, 16'h4441, 3'h5, 1'b1);
      chk("cursor phase", 32'(PH_3PI_4), 32'(seen.phase));
      chk("cursor luma", 32'(IRE_KCHROM_1), 32'(seen.luma));
      cs(8'h06, 8'h0A, 16'h4441, 3'h5, 1'b1);
      chk("cursor luma", 32'(IRE_KCHROM_0), 32'(seen.luma));
      cs(8'h06, 8'h01, 16'h4441, 3'h0, 1'b1);
      chk("cursor luma", 32'(IRE_KBLACK_1), 32'(seen.luma));
      cs(8'h06, 8'h0B, 16'h0441, 3'h2, 1'b0);
      cs(8'h02, 8'h0B, 16'h4441, 3'h2, 1'b1);
      cs(8'h04, 8'h0B, 16'h4441, 3'h5, 1'b0);
      chk("sup cursor phase", 32'(PH_NONE), 32'(seen.phase));
      cs(8'h00, 8'h0B, 16'h4441, 3'h2, 1'b0);
      $display("done cursor");
   endtask

   task automatic t_button;
      wr(OSD_CTRL_OFS, 8'h02);
      for (int s = 0; s < 2; s++) begin
         wr(ra(0), 8'(s << 7));
         for (int b = 0; b < 4; b++) begin
            px(4'h0, 16'(b << 12) | 16'h0041);
            chk("button", 32'(b), 32'(seen.button));
            chk("lowered", 32'(s), 32'(seen.button_lowered));
         end
      end
      px(4'h0, 16'h0000);
      chk("blank show", 32'h0, 32'(seen.glyph_show));
      px(4'h0, 16'h017F);
      chk("last glyph", 32'h17F, 32'(seen.glyph));
      chk("last show", 32'h1, 32'(seen.glyph_show));
      $display("done buttons");
   endtask

   task automatic t_rows;
      for (int i = 0; i < OSD_ROWS; i++) wr(ra(i), 8'(i << 6));
      for (int i = 0; i < OSD_ROWS; i++) begin
         px(4'(i), 16'h0041);
         chk("row size", 32'(i % 2), 32'(seen.double_size));
         chk("row style", 32'((i / 2) % 2),
            32'(seen.button_lowered));
      end
      $display("done rows");
   endtask

   task automatic t_vsync;
      logic [31:0] d;
      wr(OSD_CTRL_OFS, 8'h03);
      wr(ra(0), 8'h40);
      px(4'h0, 16'h0041);
      chk("before vsync", 32'h0, 32'(seen.double_size));
      rd(ra(0), d);
      chk("shadow read", 32'h40, d);
      @(posedge aclk);
      vsync <= 1'b1;
      repeat (2) @(posedge aclk);
      vsync <= 1'b0;
      px(4'h0, 16'h0041);
      chk("after vsync", 32'h1, 32'(seen.double_size));
      $display("done vsync");
   endtask

   task automatic t_stop;
      logic [31:0] d;
      wr(OSD_CTRL_OFS, 8'h00);
      wr(ra(5), 8'hFF);
      wr(OSD_CTRL_OFS, 8'h08);
      rd(ra(5), d);
      chk("stopped row", 32'h0, d);
      wr(OSD_CTRL_OFS, 8'h00);
      rd(ra(5), d);
      chk("after stop", 32'h0, d);
      $display("done stop");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      $display("[FAIL] watchdog expected done seen hang");
      tally_and_finish();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, vsync, cvalid} = '0;
      {awaddr, araddr, crow, cword, wdata} = '0;
      wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_text();
      t_super();
      t_cursor();
      t_button();
      t_rows();
      t_vsync();
      t_stop();
      tally_and_finish();
   end
endmodule
`default_nettype wire
